// *** src/hpc_pkg.sv ***
// Constants and types for the homing and position capture unit
// Operation
// - In position unit mode an active limit switch stops motion.
// - Reverse limit input logic setting 5 ignores that limit switch.
// - One selected event; up to 4 occurrences captured.
// - Each capture latches main and auxiliary positions together.
// - Main homing updates only the main position counter.
// - Writing 1 to the arm parameter starts a homing process.
// - Writing n of 1 to 4 launches n captures; arm decrements each.
// - Writing 0 disarms; arm clears itself when homing completes.
// - Event code 0 triggers at once when armed.
// - Codes 1-4: home rise, home fall, index rise, index fall.
// - Codes 5-8: reverse high/low, forward high/low, by level.
// - Action 0 stops, 1 drives output value, 2 does nothing.
// - Update 0 loads value, 1 loads counter minus value, 2 none.
// - Results read at indices 7-14, main then auxiliary per occurrence.
// - Home and index events are timed at full clock resolution.
// - Limits and digital inputs are seen only on sampling ticks.
package hpc_pkg;
    // ===========================================================
    // Parameter indices
    localparam logic [3:0] IDX_ARM = 4'h1;
    localparam logic [3:0] IDX_HOMEVAL = 4'h2;
    localparam logic [3:0] IDX_EVSEL = 4'h3;
    localparam logic [3:0] IDX_ACTION = 4'h4;
    localparam logic [3:0] IDX_UPDATE = 4'h5;
    localparam logic [3:0] IDX_OUTVAL = 4'h6;
    localparam logic [3:0] IDX_RES_FIRST = 4'h7;
    localparam logic [3:0] IDX_RES_LAST = 4'he;
    // ===========================================================
    // Codes
    localparam logic [2:0] ARM_MAX = 3'h4;
    localparam logic [4:0] EV_IMMEDIATE = 5'h00;
    localparam logic [4:0] EV_LEVEL_FIRST = 5'h05;
    localparam logic [4:0] EV_LAST = 5'h10;
    localparam logic [1:0] ACT_STOP = 2'h0;
    localparam logic [1:0] ACT_OUTPUT = 2'h1;
    localparam logic [1:0] ACT_NONE = 2'h2;
    localparam logic [1:0] UPD_LOAD = 2'h0;
    localparam logic [1:0] UPD_OFFSET = 2'h1;
    localparam logic [1:0] UPD_NONE = 2'h2;
    localparam logic [3:0] MODE_POSITION = 4'h5;
    localparam logic [3:0] LOGIC_IGNORE = 4'h5;
    // ===========================================================
    // Reset values and timing
    localparam logic [1:0] ACTION_RST = 2'h2;
    localparam logic [1:0] UPDATE_RST = 2'h2;
    localparam int CLK_MHZ = 125;
    localparam int SAMPLE_PERIOD_US = 100;
    localparam int SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_US * CLK_MHZ;
    // ===========================================================
    // Event pins
    typedef struct packed {
        logic homeSw;
        logic indexPulse;
        logic revLimit;
        logic fwdLimit;
        logic [3:0] digIn;
    } hpc_pins_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_DONE = 3'b100
    } hpc_state_t;
endpackage

// *** src/hpc_homing_capture.sv ***
// Main homing and position capture unit
`timescale 1ns/1ps
module hpc_homing_capture #(
    parameter int POS_W = 32,
    parameter int OUT_W = 8,
    parameter int SAMPLE_CYCLES = hpc_pkg::SAMPLE_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire hpc_pkg::hpc_pins_t pinsIn,
    input wire logic [3:0] unitMode,
    input wire logic [3:0] revLimitLogic,
    input wire logic [3:0] fwdLimitLogic,
    input wire logic [POS_W-1:0] mainPos,
    input wire logic [POS_W-1:0] auxPos,
    input wire logic paramWrStb,
    input wire logic [3:0] paramIdx,
    input wire logic [POS_W-1:0] paramWrData,
    output logic [POS_W-1:0] paramRdData,
    output logic limitStop,
    output logic stopMotion,
    output logic [OUT_W-1:0] digOut,
    output logic mainLoadStb,
    output logic [POS_W-1:0] mainLoadVal,
    output logic [2:0] armCount
);
    // ===========================================================
    // Pin synchronisers and sampling tick
    hpc_pkg::hpc_pins_t sync1_q, sync2_q, prev_q;
    logic [15:0] divCnt_q;
    logic sampleTick;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= pinsIn;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end
    assign sampleTick = (divCnt_q == 16'(SAMPLE_CYCLES - 1));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= sampleTick ? '0 : divCnt_q + 16'h0001;
        end
    end

    // ===========================================================
    // Limit switch stop
    logic posMode, revStops, fwdStops, limitStop_q;
    assign posMode = (unitMode == hpc_pkg::MODE_POSITION);
    assign revStops = sync2_q.revLimit && (revLimitLogic != hpc_pkg::LOGIC_IGNORE);
    assign fwdStops = sync2_q.fwdLimit && (fwdLimitLogic != hpc_pkg::LOGIC_IGNORE);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            limitStop_q <= 1'b0;
        end else if (sampleTick) begin
            limitStop_q <= posMode && (revStops || fwdStops);
        end
    end
    assign limitStop = limitStop_q;

    // ===========================================================
    // Event decode
    logic [2:0] arm_q;
    logic [POS_W-1:0] homeVal_q;
    logic [4:0] evSel_q;
    logic [1:0] action_q, update_q;
    logic [OUT_W-1:0] outVal_q;
    hpc_pkg::hpc_state_t state_q;
    logic [16:0] evVec, lvlVec;
    logic isLevelEv, levelNow, gate_q, evHit, capture, armWr, done;
    // Home and index use every clock; levels wait for the sampling tick
    assign lvlVec = {~sync2_q.digIn[3], sync2_q.digIn[3], ~sync2_q.digIn[2], sync2_q.digIn[2],
                     ~sync2_q.digIn[1], sync2_q.digIn[1], ~sync2_q.digIn[0], sync2_q.digIn[0],
                     ~sync2_q.fwdLimit, sync2_q.fwdLimit, ~sync2_q.revLimit,
                     sync2_q.revLimit, 5'h00};
    assign evVec = {lvlVec[16:5] & {12{sampleTick}},
                    ~sync2_q.indexPulse & prev_q.indexPulse,
                    sync2_q.indexPulse & ~prev_q.indexPulse,
                    ~sync2_q.homeSw & prev_q.homeSw,
                    sync2_q.homeSw & ~prev_q.homeSw,
                    1'b1};
    assign isLevelEv = (evSel_q >= hpc_pkg::EV_LEVEL_FIRST);
    assign levelNow = (evSel_q <= hpc_pkg::EV_LAST) && lvlVec[evSel_q];
    assign evHit = (evSel_q <= hpc_pkg::EV_LAST) && evVec[evSel_q] && !(isLevelEv && gate_q);
    assign armWr = paramWrStb && (paramIdx == hpc_pkg::IDX_ARM);
    assign capture = (state_q == hpc_pkg::ST_ARMED) && evHit && !armWr;
    assign done = capture && (arm_q == 3'h1);

    // ===========================================================
    // Control sequence
    logic [2:0] armWrVal;
    logic [1:0] slot_q;
    logic [POS_W-1:0] capMem_q [0:7];
    assign armWrVal = (paramWrData > POS_W'(hpc_pkg::ARM_MAX)) ? hpc_pkg::ARM_MAX
                                                                 : paramWrData[2:0];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hpc_pkg::ST_IDLE;
            arm_q <= '0;
            slot_q <= '0;
            gate_q <= 1'b0;
        end else begin
            if (capture || (sampleTick && !levelNow)) begin
                gate_q <= capture;
            end
            unique case (state_q)
                hpc_pkg::ST_IDLE: begin
                    if (armWr && armWrVal != 3'h0) begin
                        state_q <= hpc_pkg::ST_ARMED;
                    end
                end
                hpc_pkg::ST_ARMED: begin
                    if (armWr && armWrVal == 3'h0) begin
                        state_q <= hpc_pkg::ST_IDLE;
                    end else if (done) begin
                        state_q <= hpc_pkg::ST_DONE;
                    end
                end
                hpc_pkg::ST_DONE: begin
                    state_q <= (armWr && armWrVal != 3'h0) ? hpc_pkg::ST_ARMED
                                                            : hpc_pkg::ST_IDLE;
                end
            endcase
            if (armWr) begin
                arm_q <= armWrVal;
                slot_q <= '0;
                gate_q <= 1'b0;
            end else if (capture) begin
                arm_q <= arm_q - 3'h1;
                slot_q <= slot_q + 2'h1;
            end
        end
    end
    assign armCount = arm_q;

    // Capture memory: pair per occurrence, main first
    always_ff @(posedge ref_clk) begin
        if (capture) begin
            capMem_q[{slot_q, 1'b0}] <= mainPos;
            capMem_q[{slot_q, 1'b1}] <= auxPos;
        end
    end

    // ===========================================================
    // Parameter writes and readback
    logic [POS_W-1:0] rdData;
    logic [3:0] resIdx;
    assign resIdx = paramIdx - hpc_pkg::IDX_RES_FIRST;
    always_comb begin
        rdData = '0;
        unique case (paramIdx)
            hpc_pkg::IDX_ARM: rdData = POS_W'(arm_q);
            hpc_pkg::IDX_HOMEVAL: rdData = homeVal_q;
            hpc_pkg::IDX_EVSEL: rdData = POS_W'(evSel_q);
            hpc_pkg::IDX_ACTION: rdData = POS_W'(action_q);
            hpc_pkg::IDX_UPDATE: rdData = POS_W'(update_q);
            hpc_pkg::IDX_OUTVAL: rdData = POS_W'(outVal_q);
            default: begin
                if (paramIdx >= hpc_pkg::IDX_RES_FIRST && paramIdx <= hpc_pkg::IDX_RES_LAST) begin
                    rdData = capMem_q[resIdx[2:0]];
                end
            end
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            homeVal_q <= '0;
            evSel_q <= hpc_pkg::EV_IMMEDIATE;
            action_q <= hpc_pkg::ACTION_RST;
            update_q <= hpc_pkg::UPDATE_RST;
            outVal_q <= '0;
            paramRdData <= '0;
        end else begin
            paramRdData <= rdData;
            if (paramWrStb) begin
                unique case (paramIdx)
                    hpc_pkg::IDX_HOMEVAL: homeVal_q <= paramWrData;
                    hpc_pkg::IDX_EVSEL: evSel_q <= paramWrData[4:0];
                    hpc_pkg::IDX_ACTION: action_q <= paramWrData[1:0];
                    hpc_pkg::IDX_UPDATE: update_q <= paramWrData[1:0];
                    hpc_pkg::IDX_OUTVAL: outVal_q <= paramWrData[OUT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ===========================================================
    // Completion actions; only the update acts on the main counter
    logic [POS_W-1:0] lastMain_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stopMotion <= 1'b0;
            digOut <= '0;
            mainLoadStb <= 1'b0;
            mainLoadVal <= '0;
            lastMain_q <= '0;
        end else begin
            if (capture) begin
                lastMain_q <= mainPos;
            end
            stopMotion <= (state_q == hpc_pkg::ST_DONE) && (action_q == hpc_pkg::ACT_STOP);
            if (state_q == hpc_pkg::ST_DONE && action_q == hpc_pkg::ACT_OUTPUT) begin
                digOut <= outVal_q;
            end
            mainLoadStb <= (state_q == hpc_pkg::ST_DONE) && (update_q != hpc_pkg::UPD_NONE);
            if (state_q == hpc_pkg::ST_DONE) begin
                mainLoadVal <= (update_q == hpc_pkg::UPD_OFFSET) ? lastMain_q - homeVal_q
                                                                  : homeVal_q;
            end
        end
    end

    // ===========================================================
    // Checks
    property p_limit_stop;
        @(posedge ref_clk) disable iff (!rst_n)
        sampleTick && posMode && sync2_q.revLimit && revLimitLogic != hpc_pkg::LOGIC_IGNORE
        |=> limitStop;
    endproperty
    a_limit_stop: assert property (p_limit_stop) else $error("limit not stopping");
    property p_rev_ignore;
        @(posedge ref_clk) disable iff (!rst_n)
        sampleTick && revLimitLogic == hpc_pkg::LOGIC_IGNORE && !fwdStops |=> !limitStop;
    endproperty
    a_rev_ignore: assert property (p_rev_ignore) else $error("ignored limit stops");
    property p_arm_dec;
        @(posedge ref_clk) disable iff (!rst_n)
        capture && arm_q > 3'h1 |=> arm_q == $past(arm_q) - 3'h1 && state_q == hpc_pkg::ST_ARMED;
    endproperty
    a_arm_dec: assert property (p_arm_dec) else $error("arm count not decremented");
    property p_arm_done;
        @(posedge ref_clk) disable iff (!rst_n)
        done |=> arm_q == 3'h0 ##1 (arm_q == 3'h0 || $past(armWr));
    endproperty
    a_arm_done: assert property (p_arm_done) else $error("arm not cleared at end");
    property p_immediate;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == hpc_pkg::ST_ARMED && evSel_q == hpc_pkg::EV_IMMEDIATE && !armWr |-> capture;
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate event missed");
    property p_index_rise;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == hpc_pkg::ST_ARMED && evSel_q == 5'h03 && !armWr
        && sync2_q.indexPulse && !prev_q.indexPulse |-> capture;
    endproperty
    a_index_rise: assert property (p_index_rise) else $error("index edge missed");
    property p_latch;
        @(posedge ref_clk) disable iff (!rst_n)
        capture |=> capMem_q[{$past(slot_q), 1'b0}] == $past(mainPos)
        && capMem_q[{$past(slot_q), 1'b1}] == $past(auxPos);
    endproperty
    a_latch: assert property (p_latch) else $error("capture pair wrong");
    property p_stop_act;
        @(posedge ref_clk) disable iff (!rst_n)
        done && action_q == hpc_pkg::ACT_STOP && !paramWrStb |=> ##1 stopMotion ##1 !stopMotion;
    endproperty
    a_stop_act: assert property (p_stop_act) else $error("stop action missing");
    property p_load;
        @(posedge ref_clk) disable iff (!rst_n)
        done && update_q == hpc_pkg::UPD_LOAD && !paramWrStb
        |=> ##1 mainLoadStb && mainLoadVal == $past(homeVal_q);
    endproperty
    a_load: assert property (p_load) else $error("homing value not loaded");
    property p_slot_reset;
        @(posedge ref_clk) disable iff (!rst_n)
        armWr |=> slot_q == 2'h0;
    endproperty
    a_slot_reset: assert property (p_slot_reset) else $error("slot not reset on arm");
    property p_limit_tick;
        @(posedge ref_clk) disable iff (!rst_n)
        !sampleTick |=> $stable(limitStop);
    endproperty
    a_limit_tick: assert property (p_limit_tick) else $error("limit moved off tick");
endmodule

// *** sim/hpc_pin_model.sv ***
// Switch, index and digital input model driving the capture unit pins
`timescale 1ns/1ps
module hpc_pin_model #(
    parameter int DELAY_NS = 3
) (
    input wire hpc_pkg::hpc_pins_t reqPins,
    output hpc_pkg::hpc_pins_t pinsOut
);
    // ==========================================================
    // Pins move off the clock edge, as real switches do
    initial pinsOut = '0;
    always @(reqPins) begin
        pinsOut <= #(DELAY_NS) reqPins;
    end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the homing and position capture unit
`timescale 1ns/1ps
module tb;
    localparam int SAMP = 8;
    logic ref_clk, rst_n, paramWrStb, limitStop, stopMotion, mainLoadStb;
    hpc_pkg::hpc_pins_t reqPins, pinsIn;
    logic [3:0] unitMode, revLimitLogic, fwdLimitLogic, paramIdx;
    logic [31:0] mainPos, auxPos, paramWrData, paramRdData, mainLoadVal;
    logic [31:0] rnd, got, p1, p2, hv, lastLoad;
    logic [31:0] pm[4], pa[4];
    logic [7:0] digOut, outv;
    logic [2:0] armCount;
    int failures, testsRun, stopCyc, loadCyc;

    hpc_pin_model i_hpc_pin_model (.reqPins(reqPins), .pinsOut(pinsIn));
    hpc_homing_capture #(.SAMPLE_CYCLES(SAMP)) i_hpc_homing_capture (
        .ref_clk(ref_clk), .rst_n(rst_n), .pinsIn(pinsIn), .unitMode(unitMode),
        .revLimitLogic(revLimitLogic), .fwdLimitLogic(fwdLimitLogic),
        .mainPos(mainPos), .auxPos(auxPos), .paramWrStb(paramWrStb),
        .paramIdx(paramIdx), .paramWrData(paramWrData), .paramRdData(paramRdData),
        .limitStop(limitStop), .stopMotion(stopMotion), .digOut(digOut),
        .mainLoadStb(mainLoadStb), .mainLoadVal(mainLoadVal), .armCount(armCount));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Counts pulse cycles of the completion outputs
    always @(negedge ref_clk) begin
        if (stopMotion === 1'b1) stopCyc++;
        if (mainLoadStb === 1'b1) begin
            loadCyc++;
            lastLoad = mainLoadVal;
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // Pin pattern that makes event code c active or inactive
    function automatic hpc_pkg::hpc_pins_t pins_for(input int c, input logic act);
        hpc_pkg::hpc_pins_t p;
        logic lv;
        p = '0;
        lv = (c % 2 == 1) ? act : ~act;
        if (c <= 2) p.homeSw = lv;
        else if (c <= 4) p.indexPulse = lv;
        else if (c <= 6) p.revLimit = lv;
        else if (c <= 8) p.fwdLimit = lv;
        else p.digIn[(c - 9) / 2] = lv;
        return p;
    endfunction
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        @(negedge ref_clk);
        paramWrStb = 1'b1;
        paramIdx = i;
        paramWrData = d;
        @(negedge ref_clk);
        paramWrStb = 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] i, input logic [31:0] e);
        @(negedge ref_clk);
        paramIdx = i;
        @(negedge ref_clk);
        chk(paramRdData, e);
    endtask
    task automatic wait_arm(input logic [2:0] t, input int bound);
        int k;
        k = 0;
        while (armCount !== t && k < bound) begin
            @(negedge ref_clk);
            k++;
        end
        if (armCount !== t) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, armCount, t);
            final_report();
        end
    endtask
    task automatic newpos();
        rnd = lfsr(rnd);
        mainPos = rnd;
        rnd = lfsr(rnd);
        auxPos = rnd;
    endtask

    initial begin
        #700000;
        failures++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        paramWrStb = 1'b0;
        paramIdx = 4'h0;
        paramWrData = 32'h0;
        unitMode = hpc_pkg::MODE_POSITION;
        revLimitLogic = hpc_pkg::LOGIC_IGNORE;
        fwdLimitLogic = hpc_pkg::LOGIC_IGNORE;
        mainPos = 32'h0;
        auxPos = 32'h0;
        reqPins = '0;
        rnd = 32'hf4c4;
        failures = 0;
        testsRun = 0;
        stopCyc = 0;
        loadCyc = 0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        chk(armCount, 32'h0);
        chk_rd(hpc_pkg::IDX_ACTION, hpc_pkg::ACTION_RST);
        chk_rd(hpc_pkg::IDX_UPDATE, hpc_pkg::UPDATE_RST);
        $display("test reset done");
        newpos();
        hv = lfsr(rnd);
        wr(hpc_pkg::IDX_HOMEVAL, hv);
        wr(hpc_pkg::IDX_EVSEL, hpc_pkg::EV_IMMEDIATE);
        wr(hpc_pkg::IDX_ACTION, hpc_pkg::ACT_STOP);
        wr(hpc_pkg::IDX_UPDATE, hpc_pkg::UPD_LOAD);
        wr(hpc_pkg::IDX_ARM, 32'h2);
        wait_arm(3'h0, 10);
        cyc(4);
        chk_rd(4'h7, mainPos);
        chk_rd(4'h8, auxPos);
        chk_rd(4'h9, mainPos);
        chk_rd(4'ha, auxPos);
        chk(stopCyc, 32'h1);
        chk(loadCyc, 32'h1);
        chk(lastLoad, hv);
        $display("test immediate done");
        outv = rnd[7:0];
        hv = lfsr(hv);
        wr(hpc_pkg::IDX_OUTVAL, {24'h0, outv});
        wr(hpc_pkg::IDX_EVSEL, 32'h1);
        wr(hpc_pkg::IDX_ACTION, hpc_pkg::ACT_OUTPUT);
        wr(hpc_pkg::IDX_UPDATE, hpc_pkg::UPD_OFFSET);
        wr(hpc_pkg::IDX_HOMEVAL, hv);
        stopCyc = 0;
        loadCyc = 0;
        wr(hpc_pkg::IDX_ARM, 32'h7);
        chk(armCount, 32'h4);
        for (int k = 0; k < 4; k++) begin
            newpos();
            pm[k] = mainPos;
            pa[k] = auxPos;
            cyc(3);
            reqPins = pins_for(1, 1'b1);
            wait_arm(3'(3 - k), 4);
            reqPins = pins_for(1, 1'b0);
            cyc(5);
        end
        cyc(4);
        for (int k = 0; k < 4; k++) begin
            chk_rd(4'(7 + 2 * k), pm[k]);
            chk_rd(4'(8 + 2 * k), pa[k]);
        end
        chk(digOut, {24'h0, outv});
        chk(stopCyc, 32'h0);
        chk(loadCyc, 32'h1);
        chk(lastLoad, pm[3] - hv);
        $display("test multi capture done");
        wr(hpc_pkg::IDX_ACTION, hpc_pkg::ACT_NONE);
        wr(hpc_pkg::IDX_UPDATE, hpc_pkg::UPD_NONE);
        stopCyc = 0;
        loadCyc = 0;
        for (int c = 1; c <= 16; c++) begin
            reqPins = pins_for(c, 1'b0);
            cyc(20);
            wr(hpc_pkg::IDX_EVSEL, c);
            wr(hpc_pkg::IDX_ARM, 32'h2);
            newpos();
            p1 = mainPos;
            cyc(2);
            reqPins = pins_for(c, 1'b1);
            cyc(30);
            chk(armCount, 32'h1);
            chk_rd(4'h7, p1);
            reqPins = pins_for(c, 1'b0);
            cyc(20);
            newpos();
            p2 = mainPos;
            reqPins = pins_for(c, 1'b1);
            wait_arm(3'h0, 40);
            chk_rd(4'h9, p2);
            chk(limitStop, 32'h0);
        end
        chk(stopCyc + loadCyc, 32'h0);
        $display("test event codes done");
        wr(hpc_pkg::IDX_ACTION, hpc_pkg::ACT_STOP);
        wr(hpc_pkg::IDX_EVSEL, 32'h11);
        wr(hpc_pkg::IDX_ARM, 32'h1);
        reqPins = '1;
        cyc(30);
        chk(armCount, 32'h1);
        wr(hpc_pkg::IDX_ARM, 32'h0);
        chk(armCount, 32'h0);
        cyc(4);
        chk(stopCyc, 32'h0);
        $display("test disarm done");
        reqPins = '0;
        reqPins.revLimit = 1'b1;
        revLimitLogic = 4'h0;
        cyc(16);
        chk(limitStop, 32'h1);
        revLimitLogic = hpc_pkg::LOGIC_IGNORE;
        cyc(16);
        chk(limitStop, 32'h0);
        unitMode = 4'h0;
        revLimitLogic = 4'h0;
        cyc(16);
        chk(limitStop, 32'h0);
        unitMode = hpc_pkg::MODE_POSITION;
        reqPins = '0;
        reqPins.fwdLimit = 1'b1;
        fwdLimitLogic = 4'h0;
        cyc(16);
        chk(limitStop, 32'h1);
        $display("test limit stop done");
        final_report();
    end
endmodule
